// file: pmac_phy_mode_cfg.sv
// per-port phy mode, energy detect and management address registers
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "pmac_consts.svh"

module pmac_phy_mode_cfg
   import pmac_pkg::*;
#(
   parameter int unsigned ENERGY_TIMEOUT_CYC = `PMAC_ENERGY_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic port_phy_rst,
   input wire logic soft_phy_rst,
   input wire logic strap_autoneg,
   input wire logic strap_speed,
   input wire logic strap_duplex,
   input wire logic [4:0] strap_phy_addr,
   input wire logic line_energy_seen,
   input wire logic loader_wr,
   input wire logic [15:0] loader_data,
   input wire pmac_bus_req_t bus_req,
   output logic [15:0] bus_rdata,
   output logic irq,
   output pmac_phy_cfg_t phy_cfg
);

   pmac_state_t st_reg;
   pmac_state_t st_next;

   // mode field default from captured straps
   function automatic pmac_mode_t strap_mode(input pmac_strap_t s);
      if (s.autoneg) begin
         strap_mode = pmac_mode_t'(`PMAC_MODE_ALL_CAPABLE);
      end else begin
         strap_mode = pmac_mode_t'({1'b0, s.speed, s.duplex});
      end
   endfunction

   // decode of the mode field into phy controls
   function automatic pmac_phy_cfg_t decode_mode(input pmac_mode_t m, input logic edpd, input logic [4:0] a);
      pmac_phy_cfg_t c;
      c = '0;
      c.energy_detect_powerdown_en = edpd;
      c.phy_mgmt_address = a;
      c.scrambler_seed = a;
      case (m)
         PMAC_M10_HALF: begin
            c.speed_100 = 1'b0;
         end
         PMAC_M10_FULL: begin
            c.full_duplex = 1'b1;
         end
         PMAC_M100_HALF: begin
            c.speed_100 = 1'b1;
            c.crs_on_tx = 1'b1;
         end
         PMAC_M100_FULL: begin
            c.speed_100 = 1'b1;
            c.full_duplex = 1'b1;
         end
         PMAC_MPOWER_DOWN: begin
            c.power_down = 1'b1;
         end
         PMAC_MALL_CAPABLE: begin
            c.autoneg_en = 1'b1;
            c.speed_100 = 1'b1;
            c.full_duplex = 1'b1;
         end
         default: begin
            c.power_down = 1'b0; // reserved codes: phy idles in 10 half
         end
      endcase
      decode_mode = c;
   endfunction

   // register read image
   function automatic logic [15:0] read_word(input pmac_state_t s, input logic [4:0] a);
      logic [15:0] w;
      w = 16'h0000;
      case (a)
         `PMAC_OFS_ENERGY_CTRL: begin
            w[`PMAC_BIT_EDPD] = s.edpd_en;
            w[`PMAC_BIT_ENERGY] = s.energy;
            w[`PMAC_BIT_RSVD0] = s.rsvd0;
         end
         `PMAC_OFS_SPECIAL: begin
            w[`PMAC_MODE_HI:`PMAC_MODE_LO] = s.mode;
            w[`PMAC_ADDR_HI:`PMAC_ADDR_LO] = s.addr;
         end
         `PMAC_OFS_IRQ_STAT: begin
            w[2:0] = s.irq_stat;
         end
         `PMAC_OFS_IRQ_MASK: begin
            w[2:0] = s.irq_mask;
         end
         default: begin
            w = 16'h0000; // unmapped reads as zero
         end
      endcase
      read_word = w;
   endfunction

   // next-state logic
   always_comb begin
      logic [2:0] ev;
      logic wr_ctl;
      logic wr_spc;
      st_next = st_reg;
      ev = 3'h0;
      wr_ctl = bus_req.wr && (bus_req.addr == `PMAC_OFS_ENERGY_CTRL);
      wr_spc = bus_req.wr && (bus_req.addr == `PMAC_OFS_SPECIAL);

      // first cycle after release: catch straps, load defaults
      if (!st_reg.straps_taken) begin
         st_next.straps_taken = 1'b1;
         st_next.strap = '{autoneg: strap_autoneg, speed: strap_speed,
                           duplex: strap_duplex, addr: strap_phy_addr};
         st_next.mode = strap_mode(st_next.strap);
         st_next.addr = strap_phy_addr;
      end else if (port_phy_rst) begin
         // per-port reset restores protected and ordinary bits
         st_next.mode = strap_mode(st_reg.strap);
         st_next.addr = st_reg.strap.addr;
         st_next.edpd_en = 1'b0;
         st_next.rsvd0 = 1'b0;
      end else if (soft_phy_rst) begin
         // soft reset: mode/addr kept, energy kept, irq status/mask kept, edpd_en and rsvd0 to default
         st_next.edpd_en = 1'b0;
         st_next.rsvd0 = 1'b0;
      end else begin
         if (wr_ctl) begin
            st_next.edpd_en = bus_req.wdata[`PMAC_BIT_EDPD];
            st_next.rsvd0 = bus_req.wdata[`PMAC_BIT_RSVD0];
         end
         if (loader_wr) begin
            st_next.mode = pmac_mode_t'(loader_data[`PMAC_MODE_HI:`PMAC_MODE_LO]);
            st_next.addr = loader_data[`PMAC_ADDR_HI:`PMAC_ADDR_LO];
            ev[`PMAC_IRQ_RELOAD] = 1'b1;
         end else if (wr_spc) begin
            st_next.mode = pmac_mode_t'(bus_req.wdata[`PMAC_MODE_HI:`PMAC_MODE_LO]);
            st_next.addr = bus_req.wdata[`PMAC_ADDR_HI:`PMAC_ADDR_LO];
         end
      end

      // energy flag: set on energy, cleared after a quiet timeout
      if (line_energy_seen) begin
         st_next.quiet_cnt = 32'h0;
         if (!st_reg.energy) begin
            ev[`PMAC_IRQ_ENERGY_FOUND] = 1'b1;
         end
         st_next.energy = 1'b1;
      end else if (st_reg.energy) begin
         if (st_reg.quiet_cnt >= 32'(ENERGY_TIMEOUT_CYC - 1)) begin
            st_next.energy = 1'b0;
            st_next.quiet_cnt = 32'h0;
            ev[`PMAC_IRQ_ENERGY_LOST] = 1'b1;
         end else begin
            st_next.quiet_cnt = st_reg.quiet_cnt + 32'h1;
         end
      end

      // status: read clears, a new event wins over the clear
      if (bus_req.wr && (bus_req.addr == `PMAC_OFS_IRQ_MASK)) begin
         st_next.irq_mask = bus_req.wdata[2:0];
      end
      if (bus_req.rd && (bus_req.addr == `PMAC_OFS_IRQ_STAT)) begin
         st_next.irq_stat = ev;
      end else begin
         st_next.irq_stat = st_reg.irq_stat | ev;
      end
      st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

      // read data one cycle after the strobe
      st_next.rdata = bus_req.rd ? read_word(st_reg, bus_req.addr) : 16'h0000;
      st_next.cfg = decode_mode(st_next.mode, st_next.edpd_en, st_next.addr);
   end

   // state register; hard reset sets energy flag
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
         st_reg.energy <= 1'b1;
         st_reg.mode <= PMAC_MALL_CAPABLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus_rdata = st_reg.rdata;
   assign irq = st_reg.irq;
   assign phy_cfg = st_reg.cfg;

endmodule
`default_nettype wire

// file: pmac_consts.svh
// offsets, field positions, reset values and timing counts of the phy mode and address block
`ifndef PMAC_CONSTS_SVH
`define PMAC_CONSTS_SVH
`define PMAC_OFS_ENERGY_CTRL 5'h11
`define PMAC_OFS_SPECIAL 5'h12
`define PMAC_OFS_IRQ_STAT 5'h1C
`define PMAC_OFS_IRQ_MASK 5'h1D
`define PMAC_BIT_EDPD 13
`define PMAC_BIT_ENERGY 1
`define PMAC_BIT_RSVD0 0
`define PMAC_MODE_HI 7
`define PMAC_MODE_LO 5
`define PMAC_ADDR_HI 4
`define PMAC_ADDR_LO 0
`define PMAC_MODE_ALL_CAPABLE 3'h7
`define PMAC_ENERGY_TIMEOUT_MS 256
`define PMAC_CLK_HZ 20000000
`define PMAC_ENERGY_TIMEOUT_CYC (`PMAC_ENERGY_TIMEOUT_MS * (`PMAC_CLK_HZ / 1000))
`define PMAC_IRQ_ENERGY_LOST 0
`define PMAC_IRQ_ENERGY_FOUND 1
`define PMAC_IRQ_RELOAD 2
`endif

// file: pmac_pkg.sv
// types of the phy mode and address block
package pmac_pkg;
   typedef enum logic [2:0] {
      PMAC_M10_HALF = 3'h0,
      PMAC_M10_FULL = 3'h1,
      PMAC_M100_HALF = 3'h2,
      PMAC_M100_FULL = 3'h3,
      PMAC_MRSVD4 = 3'h4,
      PMAC_MRSVD5 = 3'h5,
      PMAC_MPOWER_DOWN = 3'h6,
      PMAC_MALL_CAPABLE = 3'h7
   } pmac_mode_t;

   typedef struct packed {
      logic autoneg;
      logic speed;
      logic duplex;
      logic [4:0] addr;
   } pmac_strap_t;

   typedef struct packed {
      logic speed_100;
      logic full_duplex;
      logic autoneg_en;
      logic power_down;
      logic crs_on_tx;
      logic energy_detect_powerdown_en;
      logic [4:0] phy_mgmt_address;
      logic [4:0] scrambler_seed;
   } pmac_phy_cfg_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pmac_bus_req_t;

   typedef struct packed {
      logic straps_taken;
      pmac_strap_t strap;
      logic edpd_en;
      logic rsvd0;
      logic energy;
      logic [31:0] quiet_cnt;
      pmac_mode_t mode;
      logic [4:0] addr;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      logic [15:0] rdata;
      pmac_phy_cfg_t cfg;
   } pmac_state_t;
endpackage

// file: pmac_chk.sv
// assertion checker of the phy mode and address block
`timescale 1ns/100ps
`default_nettype none
module pmac_chk
   import pmac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic port_phy_rst,
   input wire logic soft_phy_rst,
   input wire logic [4:0] strap_phy_addr,
   input wire logic line_energy_seen,
   input wire logic loader_wr,
   input wire logic [15:0] loader_data,
   input wire pmac_bus_req_t bus_req,
   input wire logic [15:0] bus_rdata,
   input wire pmac_phy_cfg_t phy_cfg
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // quiet cycle: nothing may rewrite the registers
   wire q = !port_phy_rst && !soft_phy_rst && !loader_wr && !bus_req.wr;
   a_edpd_write: assert property (bus_req.wr && bus_req.addr == 5'h11 && !port_phy_rst && !soft_phy_rst ##1 q [*2]
      |-> phy_cfg.energy_detect_powerdown_en == $past(bus_req.wdata[13], 2)) else $error("edpd not applied");
   a_energy_seen: assert property ($past(line_energy_seen) && bus_req.rd && bus_req.addr == 5'h11 |=> bus_rdata[1])
      else $error("energy flag low while energy seen");
   a_loader_rewr: assert property (loader_wr && !port_phy_rst && !soft_phy_rst ##1 q [*2]
      |-> phy_cfg.phy_mgmt_address == $past(loader_data[4:0], 2)) else $error("loader data not applied");
   a_crs_mode: assert property (phy_cfg.crs_on_tx |-> phy_cfg.speed_100 && !phy_cfg.full_duplex)
      else $error("crs on tx outside 100 half");
   a_autoneg_mode: assert property (phy_cfg.autoneg_en |-> phy_cfg.speed_100 && phy_cfg.full_duplex)
      else $error("autoneg without all abilities");
   a_seed_addr: assert property (phy_cfg.scrambler_seed == phy_cfg.phy_mgmt_address)
      else $error("scrambler seed differs from address");
   a_port_rst: assert property (port_phy_rst [*2] |-> phy_cfg.phy_mgmt_address == strap_phy_addr
      && !phy_cfg.energy_detect_powerdown_en) else $error("port reset left config");
   a_soft_keep: assert property (soft_phy_rst [*2] |-> $stable(phy_cfg.phy_mgmt_address))
      else $error("soft reset changed address");
endmodule
bind pmac_phy_mode_cfg pmac_chk u_pmac_chk (.clk_sys, .arst_n, .port_phy_rst, .soft_phy_rst, .strap_phy_addr,
   .line_energy_seen, .loader_wr, .loader_data, .bus_req, .bus_rdata, .phy_cfg);
`default_nettype wire

// file: tb.sv
// testbench of the phy mode and address block
`timescale 1ns/100ps
`default_nettype none
module tb
   import pmac_pkg::*;
;
   logic clk_sys = 0, arst_n = 0, port_phy_rst = 0, soft_phy_rst = 0, loader_wr = 0, irq;
   logic strap_autoneg = 0, strap_speed = 1, strap_duplex = 0, line_energy_seen = 1;
   logic [4:0] strap_phy_addr = 5'h0A;
   logic [15:0] loader_data = 16'h0000, bus_rdata;
   pmac_bus_req_t bus_req = '0;
   pmac_phy_cfg_t phy_cfg;
   int n_fail = 0, checked = 0, cyc = 0;
   // rows: expected mode flags, then the special-modes word written
   logic [20:0] rows [7] = '{{5'h00, 16'h0001}, {5'h08, 16'h0022}, {5'h11, 16'h0044}, {5'h18, 16'h0068},
      {5'h00, 16'h0090}, {5'h02, 16'h00DF}, {5'h1C, 16'h00E0}};
   pmac_phy_mode_cfg #(.ENERGY_TIMEOUT_CYC(20)) u_pmac_phy_mode_cfg (.clk_sys, .arst_n, .port_phy_rst,
      .soft_phy_rst, .strap_autoneg, .strap_speed, .strap_duplex, .strap_phy_addr, .line_energy_seen,
      .loader_wr, .loader_data, .bus_req, .bus_rdata, .irq, .phy_cfg);
   // clock and hang limit
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         results;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys) bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys) bus_req <= '0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk_sys) bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk_sys) bus_req <= '0;
      #1 chk(bus_rdata, e);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      arst_n <= 1;
      repeat (3) @(posedge clk_sys);
      strap_speed <= 0; // late change must not count
      rd(5'h11, 16'h0002);
      rd(5'h12, 16'h004A);
      chk(phy_cfg, 16'h894A);
      for (int i = 0; i < 7; i++) begin
         wr(5'h12, rows[i][15:0]);
         repeat (2) @(posedge clk_sys);
         #1 chk(phy_cfg, {rows[i][20:16], 1'b0, rows[i][4:0], rows[i][4:0]});
         rd(5'h12, rows[i][15:0]);
      end
      $display("test modes done");
      wr(5'h11, 16'hFFFF);
      rd(5'h11, 16'h2003);
      chk(phy_cfg, 16'hE400);
      @(posedge clk_sys) soft_phy_rst <= 1;
      repeat (2) @(posedge clk_sys);
      soft_phy_rst <= 0;
      rd(5'h11, 16'h0002);
      rd(5'h12, 16'h00E0);
      line_energy_seen <= 0;
      repeat (25) @(posedge clk_sys);
      rd(5'h11, 16'h0000);
      chk({15'h0, irq}, 16'h0000); // masked event
      wr(5'h1D, 16'h0001);
      rd(5'h1D, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      rd(5'h1C, 16'h0001);
      rd(5'h1C, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      rd(5'h03, 16'h0000);
      $display("test energy done");
      @(posedge clk_sys) begin
         loader_wr <= 1;
         loader_data <= 16'h0055;
         bus_req <= '{5'h12, 16'h00E3, 1'b1, 1'b0};
      end
      @(posedge clk_sys) begin
         loader_wr <= 0;
         bus_req <= '0;
      end
      rd(5'h12, 16'h0055);
      wr(5'h11, 16'h2000);
      @(posedge clk_sys) port_phy_rst <= 1;
      repeat (3) @(posedge clk_sys);
      port_phy_rst <= 0;
      rd(5'h12, 16'h004A);
      rd(5'h11, 16'h0000);
      // mid-run hard reset: energy flag back to 1, straps caught again
      @(posedge clk_sys) arst_n <= 0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1;
      repeat (2) @(posedge clk_sys);
      rd(5'h11, 16'h0002);
      rd(5'h12, 16'h000A);
      $display("test resets done");
      results;
   end
endmodule
`default_nettype wire
